// ### rtl/ram_fifo_cfg.svh
/*
  Offsets, field positions, reset values and counts of the RAM-FIFO
  request arbiter. Assumes inclusion by bare name from the design file.
*/
`ifndef RAM_FIFO_CFG_SVH
`define RAM_FIFO_CFG_SVH

// APB byte offsets
`define OFS_SELECT 8'h00
`define OFS_WINDOW 8'h04
`define OFS_CTL_A 8'h08
`define OFS_CTL_B 8'h0C
`define OFS_CTL_C 8'h10
`define OFS_SET_ID 8'h14
`define OFS_STAT_C 8'h18
`define OFS_ARB 8'h1C

// Select register fields
`define SEL_SET_HI 7
`define SEL_SET_LO 5
`define SEL_VIEW 4
`define SEL_PTR_HI 3
`define SEL_PTR_LO 2
`define SEL_STS_HI 1
`define SEL_STS_LO 0
`define SELECT_RESET 8'h00

// Set control A fields
`define CTLA_EN 7
`define CTLA_SIZE_HI 2
`define CTLA_SIZE_LO 0

// Set status bits
`define ST_EMPTY 0
`define ST_FULL 1
`define ST_OVERREAD 2
`define ST_OVERWRITE 3

// Counts
`define NUM_IDS 14
`define NUM_SETS 8
`define GRP_A_IDS 8
`define GRP_B_IDS 6
`define MIN_FIFO 12'h010

`endif

// ### rtl/ram_fifo_pkg.sv
/*
  Types of the RAM-FIFO request arbiter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ram_fifo_pkg;
  // Transfer sequencer, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } xfer_state_t;
  typedef logic [11:0] fifo_ptr_t;
  typedef logic [15:0] ram_addr_t;
endpackage : ram_fifo_pkg

// ### rtl/ram_fifo_request_arbiter.sv
/*
  Request arbiter and pointer-set register window of the RAM-FIFO unit.
  Assumes an APB master on pclk, peripherals on pclk that hold a request
  until acknowledged, and RAM that completes within the bus cycle.
*/
`timescale 1ns/1ps
`include "ram_fifo_cfg.svh"

// Functional notes
// - set number field picks visible pointer set
// - window and set registers follow set number
// - view bit: 0 pointers, 1 FIFO status
// - pointer view maps base, read, write, temp
// - status view maps valid, free, read address, write address
// - status view needs two consecutive writes
// - serial flag set is one-byte request
// - USB requests invisible to software reads
// - fourteen IDs only, others cannot request
// - only highest priority pending ID serviced
// - group 0-7 always beats group 8-13
// - reset priority ascending ID within group
// - serviced ID becomes lowest, next highest
// - fixed byte direction per ID
// - start from base, size from control A
// - RAM address is base plus pointer
// - pointer past size wraps minus size
module ram_fifo_request_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [13:0] xfer_req,
  output logic [13:0] xfer_ack,
  output logic [3:0] xfer_id,
  output logic [15:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr
);

  ////////////////////////////////////////////////////////////////////
  // Storage
  ////////////////////////////////////////////////////////////////////
  logic [7:0] select_r; // Set number and view fields
  logic view_arm_r; // First of two status-view writes seen
  ram_fifo_pkg::ram_addr_t base_r [`NUM_SETS]; // FIFO start
  ram_fifo_pkg::fifo_ptr_t rd_r [`NUM_SETS]; // Read pointer
  ram_fifo_pkg::fifo_ptr_t wr_r [`NUM_SETS]; // Write pointer
  ram_fifo_pkg::fifo_ptr_t tmp_r [`NUM_SETS]; // Temp pointer
  logic [7:0] ctl_a_r [`NUM_SETS]; // Enable and size
  logic [7:0] ctl_b_r [`NUM_SETS]; // General control
  logic [3:0] set_id_r [`NUM_SETS]; // ID served by set
  logic [3:0] stat_r [`NUM_SETS]; // Sticky FIFO status
  logic full_r [`NUM_SETS]; // Pointers equal means full
  ram_fifo_pkg::xfer_state_t state_r; // Sequencer
  logic [2:0] prio_a_r; // Highest ID in group A
  logic [2:0] prio_b_r; // Highest offset in group B
  logic [3:0] gnt_id_r; // Granted ID
  logic [2:0] gnt_set_r; // Set of granted ID
  logic gnt_err_r; // Over-read or over-write
  logic [31:0] rdata_r; // Read data flop

  ////////////////////////////////////////////////////////////////////
  // Decode
  ////////////////////////////////////////////////////////////////////
  logic [2:0] cur; // Selected set
  logic setup; // APB setup phase
  logic wr_acc; // Write taking effect
  logic mapped; // Address hits a register
  assign cur = select_r[`SEL_SET_HI:`SEL_SET_LO];
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `OFS_ARB);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // FIFO size of a set, 16 bytes doubled per size step
  function automatic ram_fifo_pkg::fifo_ptr_t fsize(input logic [7:0] a);
    fsize = `MIN_FIFO << a[`CTLA_SIZE_HI:`CTLA_SIZE_LO];
  endfunction : fsize

  // Pointer step with wrap back by the FIFO size
  function automatic ram_fifo_pkg::fifo_ptr_t step(
    input ram_fifo_pkg::fifo_ptr_t p,
    input ram_fifo_pkg::fifo_ptr_t s
  );
    ram_fifo_pkg::fifo_ptr_t n;
    n = p + 12'h001;
    step = (n >= s) ? n - s : n;
  endfunction : step

  // Byte direction fixed by ID: 1 means into RAM
  function automatic logic into_ram(input logic [3:0] id);
    if (id < 4'h8) begin
      into_ram = id[0];
    end else if (id < 4'hC) begin
      into_ram = !id[0];
    end else begin
      into_ram = id[0];
    end
  endfunction : into_ram

  ////////////////////////////////////////////////////////////////////
  // Request eligibility, one lookup per ID
  ////////////////////////////////////////////////////////////////////
  logic [13:0] elig; // Pending with an enabled set
  logic [2:0] id_set [`NUM_IDS]; // Set serving each ID
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_IDS; gi++) begin : g_id
      logic hit;
      logic [2:0] sidx;
      always_comb begin
        hit = 1'b0;
        sidx = 3'h0;
        for (int s = 0; s < `NUM_SETS; s++) begin
          if (ctl_a_r[s][`CTLA_EN] && set_id_r[s] == 4'(gi) && !hit) begin
            hit = 1'b1;
            sidx = 3'(s);
          end
        end
      end
      assign id_set[gi] = sidx;
      assign elig[gi] = xfer_req[gi] && hit;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Round-robin pick inside each group, group A first
  ////////////////////////////////////////////////////////////////////
  logic pick_ok; // Some eligible request
  logic [3:0] pick_id; // Winner
  always_comb begin
    logic [2:0] ia;
    logic [2:0] ib;
    logic fa;
    logic fb;
    ia = 3'h0;
    ib = 3'h0;
    fa = 1'b0;
    fb = 1'b0;
    for (int k = 0; k < `GRP_A_IDS; k++) begin
      if (!fa && elig[3'(prio_a_r + 3'(k))]) begin
        fa = 1'b1;
        ia = 3'(prio_a_r + 3'(k));
      end
    end
    for (int k = 0; k < `GRP_B_IDS; k++) begin
      if (!fb && elig[8 + ((int'(prio_b_r) + k) % `GRP_B_IDS)]) begin
        fb = 1'b1;
        ib = 3'((int'(prio_b_r) + k) % `GRP_B_IDS);
      end
    end
    pick_ok = fa || fb;
    pick_id = fa ? {1'b0, ia} : 4'(4'h8 + {1'b0, ib});
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer: grant, two-state bus cycle, acknowledge
  ////////////////////////////////////////////////////////////////////
  logic pick_in; // Winner moves bytes into RAM
  logic [2:0] pset; // Set of winner
  ram_fifo_pkg::fifo_ptr_t psize; // Its FIFO size
  logic perr; // Winner would over-read or over-write
  assign pset = id_set[pick_id];
  assign pick_in = into_ram(pick_id);
  assign psize = fsize(ctl_a_r[pset]);
  assign perr = pick_in ? full_r[pset]
              : (rd_r[pset] == wr_r[pset] && !full_r[pset]);

  // State and grant capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ram_fifo_pkg::ST_IDLE;
      gnt_id_r <= 4'h0;
      gnt_set_r <= 3'h0;
      gnt_err_r <= 1'b0;
    end else begin
      case (state_r)
        ram_fifo_pkg::ST_IDLE: begin
          if (pick_ok) begin
            state_r <= ram_fifo_pkg::ST_XFER;
            gnt_id_r <= pick_id;
            gnt_set_r <= pset;
            gnt_err_r <= perr;
          end
        end
        ram_fifo_pkg::ST_XFER: state_r <= ram_fifo_pkg::ST_DONE;
        ram_fifo_pkg::ST_DONE: state_r <= ram_fifo_pkg::ST_IDLE;
        default: state_r <= ram_fifo_pkg::ST_IDLE;
      endcase
    end
  end

  // RAM address and strobes for the bus cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_addr <= 16'h0000;
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
      xfer_id <= 4'h0;
    end else if (state_r == ram_fifo_pkg::ST_IDLE && pick_ok) begin
      ram_addr <= base_r[pset]
                + {4'h0, pick_in ? wr_r[pset] : rd_r[pset]};
      ram_rd <= !pick_in && !perr;
      ram_wr <= pick_in && !perr;
      xfer_id <= pick_id;
    end else if (state_r == ram_fifo_pkg::ST_DONE) begin
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
    end
  end

  // Acknowledge clears the granted request
  always_comb begin
    xfer_ack = 14'h0000;
    if (state_r == ram_fifo_pkg::ST_DONE) begin
      xfer_ack[gnt_id_r] = 1'b1;
    end
  end

  // Priority rotation after service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_a_r <= 3'h0;
      prio_b_r <= 3'h0;
    end else if (state_r == ram_fifo_pkg::ST_DONE) begin
      if (gnt_id_r < 4'h8) begin
        prio_a_r <= 3'(gnt_id_r[2:0] + 3'h1);
      end else if (gnt_id_r == 4'hD) begin
        prio_b_r <= 3'h0;
      end else begin
        prio_b_r <= 3'(gnt_id_r - 4'h7);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Select register with double-write entry to status view
  ////////////////////////////////////////////////////////////////////
  logic sel_wr; // Write to select register
  assign sel_wr = wr_acc && paddr == `OFS_SELECT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_r <= `SELECT_RESET;
      view_arm_r <= 1'b0;
    end else if (sel_wr) begin
      select_r <= pwdata[7:0];
      view_arm_r <= 1'b0;
      if (pwdata[`SEL_VIEW] && !select_r[`SEL_VIEW] && !view_arm_r) begin
        select_r[`SEL_VIEW] <= 1'b0;
        view_arm_r <= 1'b1;
      end
    end else if (psel && penable) begin
      view_arm_r <= 1'b0; // Any other access breaks the pair
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-set registers and pointers
  ////////////////////////////////////////////////////////////////////
  logic win_wr; // Pointer view write through window
  assign win_wr = wr_acc && paddr == `OFS_WINDOW && !select_r[`SEL_VIEW];
  generate
    for (gi = 0; gi < `NUM_SETS; gi++) begin : g_set
      logic own; // Register access targets this set
      logic busy; // This set finishes a bus cycle
      ram_fifo_pkg::fifo_ptr_t sz;
      ram_fifo_pkg::fifo_ptr_t rn;
      ram_fifo_pkg::fifo_ptr_t wn;
      logic [3:0] st_set; // Status bits raised this cycle
      assign own = cur == 3'(gi);
      assign busy = state_r == ram_fifo_pkg::ST_DONE
                 && gnt_set_r == 3'(gi) && !gnt_err_r;
      assign sz = fsize(ctl_a_r[gi]);
      assign rn = step(rd_r[gi], sz);
      assign wn = step(wr_r[gi], sz);

      // Control, ID and window-written pointers
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctl_a_r[gi] <= 8'h00;
          ctl_b_r[gi] <= 8'h00;
          set_id_r[gi] <= 4'h0;
          base_r[gi] <= 16'h0000;
          tmp_r[gi] <= 12'h000;
        end else if (own && wr_acc) begin
          if (paddr == `OFS_CTL_A) ctl_a_r[gi] <= pwdata[7:0];
          if (paddr == `OFS_CTL_B) ctl_b_r[gi] <= pwdata[7:0];
          if (paddr == `OFS_SET_ID) set_id_r[gi] <= pwdata[3:0];
          if (win_wr && select_r[`SEL_PTR_HI:`SEL_PTR_LO] == 2'h0) begin
            base_r[gi] <= pwdata[15:0];
          end
          if (win_wr && select_r[`SEL_PTR_HI:`SEL_PTR_LO] == 2'h3) begin
            tmp_r[gi] <= pwdata[11:0];
          end
        end
      end

      // Read and write pointers, moved by transfers or window
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rd_r[gi] <= 12'h000;
          wr_r[gi] <= 12'h000;
          full_r[gi] <= 1'b0;
        end else if (busy && into_ram(gnt_id_r)) begin
          wr_r[gi] <= wn;
          full_r[gi] <= wn == rd_r[gi];
        end else if (busy) begin
          rd_r[gi] <= rn;
          full_r[gi] <= 1'b0;
        end else if (own && win_wr) begin
          if (select_r[`SEL_PTR_HI:`SEL_PTR_LO] == 2'h1) begin
            rd_r[gi] <= pwdata[11:0];
          end
          if (select_r[`SEL_PTR_HI:`SEL_PTR_LO] == 2'h2) begin
            wr_r[gi] <= pwdata[11:0];
          end
          full_r[gi] <= 1'b0;
        end
      end

      // Sticky status, hardware set beats software clear
      always_comb begin
        st_set = 4'h0;
        if (state_r == ram_fifo_pkg::ST_DONE && gnt_set_r == 3'(gi)) begin
          if (into_ram(gnt_id_r)) begin
            st_set[`ST_OVERWRITE] = gnt_err_r;
            st_set[`ST_FULL] = !gnt_err_r && wn == rd_r[gi];
          end else begin
            st_set[`ST_OVERREAD] = gnt_err_r;
            st_set[`ST_EMPTY] = !gnt_err_r && rn == wr_r[gi];
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat_r[gi] <= 4'h0;
        end else if (own && wr_acc && paddr == `OFS_STAT_C) begin
          stat_r[gi] <= (stat_r[gi] & pwdata[3:0]) | st_set;
        end else begin
          stat_r[gi] <= stat_r[gi] | st_set;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase
  ////////////////////////////////////////////////////////////////////
  ram_fifo_pkg::fifo_ptr_t csize; // Selected set FIFO size
  ram_fifo_pkg::fifo_ptr_t valid; // Bytes held
  assign csize = fsize(ctl_a_r[cur]);
  always_comb begin
    if (full_r[cur]) begin
      valid = csize;
    end else if (wr_r[cur] >= rd_r[cur]) begin
      valid = wr_r[cur] - rd_r[cur];
    end else begin
      valid = wr_r[cur] + csize - rd_r[cur];
    end
  end

  logic [31:0] win_val; // Window contents
  always_comb begin
    win_val = 32'h0000_0000;
    if (!select_r[`SEL_VIEW]) begin
      case (select_r[`SEL_PTR_HI:`SEL_PTR_LO])
        2'h0: win_val = {16'h0000, base_r[cur]};
        2'h1: win_val = {20'h00000, rd_r[cur]};
        2'h2: win_val = {20'h00000, wr_r[cur]};
        default: win_val = {20'h00000, tmp_r[cur]};
      endcase
    end else begin
      case (select_r[`SEL_STS_HI:`SEL_STS_LO])
        2'h0: win_val = {20'h00000, valid};
        2'h1: win_val = {20'h00000, 12'(csize - valid)};
        2'h2: win_val = {16'h0000, 16'(base_r[cur] + {4'h0, rd_r[cur]})};
        default: win_val = {16'h0000, 16'(base_r[cur] + {4'h0, wr_r[cur]})};
      endcase
    end
  end

  // Register mux; request lines themselves are never readable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `OFS_SELECT: rdata_r <= {24'h000000, select_r};
        `OFS_WINDOW: rdata_r <= win_val;
        `OFS_CTL_A: rdata_r <= {24'h000000, ctl_a_r[cur]};
        `OFS_CTL_B: rdata_r <= {24'h000000, ctl_b_r[cur]};
        `OFS_SET_ID: rdata_r <= {28'h0000000, set_id_r[cur]};
        `OFS_STAT_C: rdata_r <= {28'h0000000, stat_r[cur]};
        `OFS_ARB: rdata_r <= {24'h000000, gnt_id_r, 1'b0, state_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = rdata_r;

endmodule : ram_fifo_request_arbiter

// ### sim/ram_fifo_request_arbiter_assertions.sv
/*
  Checker of the request arbiter ports, bound to the design.
  Assumes one clock pclk and the async active-low reset presetn.
*/
`timescale 1ns/1ps
module ram_fifo_request_arbiter_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [13:0] xfer_req,
  input wire logic [13:0] xfer_ack,
  input wire logic [3:0] xfer_id,
  input wire logic [15:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Either RAM strobe
  logic strobe;
  assign strobe = ram_rd | ram_wr;
  //////////////////////////////////////////////////////////////////////////
  a_ack_onehot: assert property ($onehot0(xfer_ack))
    else $error("more than one acknowledge");
  a_ack_id: assert property (|xfer_ack |-> xfer_ack == (14'h1 << xfer_id))
    else $error("acknowledge differs from granted id");
  a_ack_cause: assert property
    (|xfer_ack |-> (xfer_ack & $past(xfer_req, 2)) == xfer_ack)
    else $error("acknowledge without a request");
  a_ack_spacing: assert property
    (|xfer_ack |=> !(|xfer_ack) ##1 !(|xfer_ack))
    else $error("transfers closer than three cycles");
  a_strobe_shape: assert property
    ($rose(strobe) |=> (strobe && |xfer_ack) ##1 !strobe)
    else $error("strobe not two cycles ending with ack");
  a_addr_hold: assert property
    ($rose(strobe) |=> $stable(ram_addr) && $stable(xfer_id))
    else $error("address or id moved during transfer");
  a_rd_dir: assert property (ram_rd |-> !ram_wr &&
    ((xfer_id < 4'h8 && !xfer_id[0]) || xfer_id inside {4'h9, 4'hB, 4'hC}))
    else $error("RAM read for a write id");
  a_wr_dir: assert property (ram_wr |->
    ((xfer_id < 4'h8 && xfer_id[0]) || xfer_id inside {4'h8, 4'hA, 4'hD}))
    else $error("RAM write for a read id");
  a_ctlc_zero: assert property
    (psel && penable && !pwrite && paddr == 8'h10 |-> prdata == 32'h0)
    else $error("control C read not zero");
  a_bad_addr: assert property (psel && penable |-> pready &&
    (pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0)))
    else $error("error response wrong for address");
endmodule : ram_fifo_request_arbiter_assertions

bind ram_fifo_request_arbiter ram_fifo_request_arbiter_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .xfer_req(xfer_req),
  .xfer_ack(xfer_ack), .xfer_id(xfer_id), .ram_addr(ram_addr),
  .ram_rd(ram_rd), .ram_wr(ram_wr)
);

// ### sim/periph_model.sv
/*
  Peripheral side: per id, issues a loaded number of byte requests.
  Assumes acknowledges on pclk; holds each request until acknowledged.
*/
`timescale 1ns/1ps
module periph_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [27:0] quota,
  input wire logic [13:0] xfer_ack,
  output logic [13:0] xfer_req
);
  // Requests still to issue, two bits per id
  logic [1:0] cnt [14];
  //////////////////////////////////////////////////////////////////////////
  // Raise, hold until ack, drop for one cycle, raise again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_req <= 14'h0;
      for (int i = 0; i < 14; i++) cnt[i] <= 2'h0;
    end else begin
      for (int i = 0; i < 14; i++) begin
        if (load) begin
          cnt[i] <= quota[2*i +: 2];
        end else if (xfer_ack[i] && xfer_req[i]) begin
          xfer_req[i] <= 1'h0;
          cnt[i] <= cnt[i] - 2'h1;
        end else begin
          xfer_req[i] <= (cnt[i] != 2'h0);
        end
      end
    end
  end
endmodule : periph_model

// ### sim/ram_fifo_request_arbiter_test.sv
/*
  Self-checking bench: APB register tests and request arbitration.
  Assumes the design, its checker and the peripheral model.
*/
`timescale 1ns/1ps
module ram_fifo_request_arbiter_test;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [13:0] xfer_req;
  logic [13:0] xfer_ack;
  logic [3:0] xfer_id;
  logic [15:0] ram_addr;
  logic ram_rd;
  logic ram_wr;
  logic load = 1'h0;
  logic [27:0] quota = 28'h0;
  int fails = 0;
  int n_checks = 0;
  logic [31:0] r; // Last read data
  logic e; // Last error response
  logic [3:0] g_id [$];
  logic [15:0] g_addr [$];
  logic [1:0] g_dir [$];
  logic [3:0] sid [6] = '{4'h1, 4'h2, 4'h5, 4'h9, 4'hD, 4'h3}; // Set ids
  logic [3:0] ord [7] = '{4'h1, 4'h2, 4'h5, 4'h1, 4'h9, 4'hD, 4'h9};
  logic [15:0] ex [4];
  int srv [14];
  //////////////////////////////////////////////////////////////////////////
  always #10 pclk = ~pclk;
  ram_fifo_request_arbiter u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_req(xfer_req), .xfer_ack(xfer_ack), .xfer_id(xfer_id),
    .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_wr(ram_wr));
  periph_model u_peer (.pclk(pclk), .presetn(presetn), .load(load),
    .quota(quota), .xfer_ack(xfer_ack), .xfer_req(xfer_req));
  // Record every acknowledged transfer
  always @(posedge pclk) begin
    if (|xfer_ack) begin
      g_id.push_back(xfer_id);
      g_addr.push_back(ram_addr);
      g_dir.push_back({ram_rd, ram_wr});
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask : rd
  function logic [15:0] bse(input int s);
    return 16'h0200 + 16'(s * 32); // Areas kept apart
  endfunction : bse
  function logic is_rd(input logic [3:0] id);
    return (id < 4'h8 && !id[0]) || id inside {4'h9, 4'hB, 4'hC};
  endfunction : is_rd
  // Set up pointer set s: enable, id, base, read 0, write wp
  task cfg(input int s, input logic en, input logic [11:0] wp);
    logic [7:0] sel;
    sel = 8'(s << 5);
    wr(8'h00, {24'h0, sel});
    wr(8'h08, en ? 32'h80 : 32'h0);
    wr(8'h14, {28'h0, sid[s]});
    wr(8'h04, {16'h0, bse(s)});
    wr(8'h00, {24'h0, sel | 8'h04});
    wr(8'h04, 32'h0);
    wr(8'h00, {24'h0, sel | 8'h08});
    wr(8'h04, {20'h0, wp});
  endtask : cfg
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    $display("watchdog expired");
    final_report;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    rd(8'h00);
    chk(r, 32'h0);
    rd(8'h10);
    chk(r, 32'h0);
    rd(8'h20);
    chk({r[30:0], e}, 32'h1);
    $display("test reset done");
    for (int s = 0; s < 6; s++) begin
      cfg(s, s != 5, is_rd(sid[s]) ? 12'h4 : (s == 4 ? 12'hF : 12'h0));
    end
    for (int s = 0; s < 6; s++) begin
      wr(8'h00, 32'(s << 5));
      rd(8'h14);
      chk(r, {28'h0, sid[s]});
    end
    wr(8'h00, 32'h2C);
    wr(8'h04, 32'h7);
    ex = '{bse(1), 16'h0, 16'h4, 16'h7};
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 32'(8'h20 | (p << 2)));
      rd(8'h04);
      chk(r, {16'h0, ex[p]});
    end
    wr(8'h00, 32'h30);
    rd(8'h04);
    chk(r, {16'h0, bse(1)});
    wr(8'h00, 32'h30);
    wr(8'h00, 32'h30);
    ex = '{16'h4, 16'hC, bse(1), bse(1) + 16'h4};
    for (int q = 0; q < 4; q++) begin
      wr(8'h00, 32'(8'h30 | q));
      rd(8'h04);
      chk(r, {16'h0, ex[q]});
    end
    wr(8'h00, 32'h0);
    $display("test windows done");
    @(posedge pclk);
    load <= 1'h1;
    quota <= 28'h4080459; // Ids 0,2,3,5,13 once; 1 and 9 twice
    @(posedge pclk);
    load <= 1'h0;
    for (int k = 0; k < 200 && g_id.size() < 7; k++) @(posedge pclk);
    chk(32'(g_id.size()), 32'h7);
    for (int i = 0; i < 7 && i < g_id.size(); i++) begin
      chk({28'h0, g_id[i]}, {28'h0, ord[i]});
      chk({30'h0, g_dir[i]}, is_rd(ord[i]) ? 32'h2 : 32'h1);
      for (int s = 0; s < 5; s++) begin
        if (sid[s] == ord[i]) begin
          ex[0] = bse(s) + 16'(srv[ord[i]]) + (s == 4 ? 16'hF : 16'h0);
        end
      end
      srv[ord[i]]++;
      chk({16'h0, g_addr[i]}, {16'h0, ex[0]});
    end
    chk({31'h0, xfer_req[0]}, 32'h1);
    chk({31'h0, xfer_req[3]}, 32'h1);
    $display("test arbitration done");
    wr(8'h00, 32'h88);
    rd(8'h04);
    chk(r, 32'h0);
    rd(8'h18);
    chk({31'h0, r[1]}, 32'h1);
    $display("test wrap done");
    final_report;
  end
endmodule : ram_fifo_request_arbiter_test
